// file: rtl/dpfs_defines.svh
/*
 * Holds the register offsets, field positions, reset values and fixed codes
 * of the daisy-port status and serial host fault block.
 * Assumes it is included by bare name, once per compilation unit.
 */
`ifndef DPFS_DEFINES_SVH
`define DPFS_DEFINES_SVH

// Printed offsets are not word multiples: they are indices, byte address = 4 * index
`define DPFS_IDX_PORT_STAT   16'h2300
`define DPFS_IDX_PHY_FAULT   16'h2301
`define DPFS_IDX_IRQ_MASK    16'h2380
`define DPFS_IDX_DEBUG_CTRL  16'h2201
`define DPFS_IDX_UNLOCK      16'h2200

// Unlock code for the manual port override
`define DPFS_UNLOCK_CODE     8'hA5
// Byte sent on the serial data out while masked
`define DPFS_FILL_BYTE       8'hFF
// Debug control reset value (manual enables set, override off)
`define DPFS_CTRL_RESET      8'h78
// Port status reset value
`define DPFS_STAT_RESET      8'h13

// Debug control fields
`define DPFS_CTRL_OVR_BIT    0
`define DPFS_CTRL_EN_LSB     3

// Port status fields
`define DPFS_STAT_AUTO_BIT   4

// Fault register fields
`define DPFS_F_FMT           6
`define DPFS_F_CLR           5
`define DPFS_F_UWR           4
`define DPFS_F_URD           3
`define DPFS_F_TOF           2
`define DPFS_F_TUF           1
`define DPFS_F_ROF           0
`define DPFS_FAULT_W         7

// Bit count at the last bit of a serial byte
`define DPFS_BYTE_BITS       3'h7

`endif

// file: rtl/dpfs_fault_if.sv
/*
 * Holds the interface that carries fault events from the frame checker.
 * Assumes both ends share pclk.
 */
`timescale 1ns/1ps
interface dpfs_fault_if;
    logic fmt_event;
    logic byte_done;
    modport checker_end (output fmt_event, output byte_done);
    modport core_end (input fmt_event, input byte_done);
endinterface : dpfs_fault_if

// file: rtl/dpfs_frame_check.sv
/*
 * Counts serial clocks during each chip-select-low period and reports
 * whole bytes and frames whose bit count is not a multiple of eight.
 * Assumes serial strobes are synchronous one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`include "dpfs_defines.svh"
module dpfs_frame_check (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Serial host strobes
    input wire logic chip_select_low,
    input wire logic sclk_pulse,
    // Events out
    dpfs_fault_if.checker_end ev
);
    import dpfs_pkg::*;

    logic [2:0] bit_cnt_reg;
    logic cs_d_reg;

    // Bit counter inside a select period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_reg <= 3'h0;
        end else if (!chip_select_low) begin
            bit_cnt_reg <= 3'h0;
        end else if (sclk_pulse) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
    end

    // Previous select level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_d_reg <= 1'b0;
        end else begin
            cs_d_reg <= chip_select_low;
        end
    end

    // Byte end and partial byte at select release
    assign ev.byte_done = chip_select_low && sclk_pulse && (bit_cnt_reg == `DPFS_BYTE_BITS);
    assign ev.fmt_event = cs_d_reg && !chip_select_low && (bit_cnt_reg != 3'h0);
endmodule : dpfs_frame_check

// file: rtl/dpfs_pkg.sv
/*
 * Holds the shared types of the daisy-port status and fault block.
 * Assumes nothing beyond the defines header.
 */
package dpfs_pkg;
    typedef logic [7:0] dpfs_byte_t;
    typedef logic [6:0] dpfs_fault_t;
    typedef enum logic [1:0] {DPFS_IDLE, DPFS_SETUP, DPFS_ACCESS} dpfs_apb_st_t;
endpackage : dpfs_pkg

// file: rtl/dpfs_sticky_bit.sv
/*
 * One sticky flag: set by hardware, cleared by writing one to it;
 * a communication clear leaves it set. Set wins over clear.
 * Assumes one-cycle set and clear strobes.
 */
`timescale 1ns/1ps
module dpfs_sticky_bit (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic set_pulse,
    input wire logic clr_pulse,
    // State
    output logic flag
);
    // Sticky flag, set has priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag <= 1'b0;
        end else if (set_pulse) begin
            flag <= 1'b1;
        end else if (clr_pulse) begin
            flag <= 1'b0;
        end
    end
endmodule : dpfs_sticky_bit

// file: rtl/dpfs_top.sv
/*
 * Holds the port status and serial host fault logic with its APB slave.
 * Assumes the serial front end and FIFOs outside give synchronous strobes.
 */
// Added by the designer: the APB register port.
// Operation
// - The auto port control flag reads 0 under unlocked manual override and 1 when the device drives both ports.
// - Four read-only bits show live low-side tx, low-side rx, high-side tx and high-side rx enables.
// - A select-low period whose clock count is not a multiple of eight raises the frame format fault.
// - A malformed clear sets the bad clear fault and is ignored, with no ready and no store.
// - Host data while unread response data waits after a timeout sets the unexpected write fault and stops storing.
// - Reading on after the first queue empties with ready low sets the unexpected read fault, stops storing, sends 0xFF.
// - Writing with both queues full sets the transmit overflow fault, stops storing and sends 0xFF.
// - Reading past empty sets the underflow fault, sends 0xFF, stops storing and holds ready low until a clear.
// - Too many host bytes set the receive overflow fault, stop storing, send 0xFF and hold ready low until a clear.
`timescale 1ns/1ps
`include "dpfs_defines.svh"
module dpfs_top (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial host events
    input wire logic chip_select_low,
    input wire logic sclk_pulse,
    input wire logic clear_good,
    input wire logic clear_bad,
    input wire logic host_write_byte,
    input wire logic resp_pending,
    input wire logic fifo1_empty,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic rx_too_many,
    input wire logic [7:0] tx_byte,
    // Port live status from the auto controller
    input wire logic [3:0] auto_port_en,
    // Port enables and data path
    output logic low_side_tx_active,
    output logic low_side_rx_active,
    output logic high_side_tx_active,
    output logic high_side_rx_active,
    output logic store_en,
    output logic host_ready,
    output dpfs_pkg::dpfs_byte_t miso_byte,
    output logic irq
);
    import dpfs_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    dpfs_fault_if fev ();
    dpfs_byte_t unlock_reg;
    dpfs_byte_t ctrl_reg;
    dpfs_fault_t mask_reg;
    dpfs_fault_t fault_flag;
    dpfs_fault_t fault_set;
    logic block_reg;
    logic block_next;
    logic manual_on;
    logic [3:0] port_en;
    logic [15:0] idx;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic clr_wr;

    // ------------------------------------------------------------
    // Frame checker and fault flags
    // ------------------------------------------------------------
    dpfs_frame_check u_chk (
        .pclk(pclk),
        .presetn(presetn),
        .chip_select_low(chip_select_low),
        .sclk_pulse(sclk_pulse),
        .ev(fev.checker_end)
    );

    // Fault causes
    always_comb begin
        fault_set = '0;
        fault_set[`DPFS_F_FMT] = fev.fmt_event;
        fault_set[`DPFS_F_CLR] = clear_bad;
        fault_set[`DPFS_F_UWR] = host_write_byte && resp_pending;
        fault_set[`DPFS_F_URD] = sclk_pulse && fifo1_empty && !host_ready && !host_write_byte;
        fault_set[`DPFS_F_TOF] = host_write_byte && fifo_full;
        fault_set[`DPFS_F_TUF] = sclk_pulse && fifo_empty && !host_write_byte;
        fault_set[`DPFS_F_ROF] = rx_too_many;
    end

    // Write-one clear strobe on the fault register
    assign clr_wr = wr_en && (idx == `DPFS_IDX_PHY_FAULT);

    genvar gi;
    generate
        for (gi = 0; gi < `DPFS_FAULT_W; gi++) begin : g_flag
            dpfs_sticky_bit u_bit (
                .pclk(pclk),
                .presetn(presetn),
                .set_pulse(fault_set[gi]),
                .clr_pulse(clr_wr && pwdata[gi]),
                .flag(fault_flag[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Data path mask
    // ------------------------------------------------------------
    // Any storing fault blocks until a good clear; a bad clear is ignored
    always_comb begin
        block_next = block_reg;
        if (clear_good && !clear_bad) begin
            block_next = 1'b0;
        end
        if (|fault_set[`DPFS_F_UWR:`DPFS_F_ROF]) begin
            block_next = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_reg <= 1'b0;
        end else begin
            block_reg <= block_next;
        end
    end

    // Storing and ready gated; bad clear never lifts them
    assign store_en = !block_reg && !clear_bad;
    assign host_ready = !block_reg && !clear_bad;

    // Output byte switches to fill at byte boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_byte <= `DPFS_FILL_BYTE;
        end else if (fev.byte_done || !chip_select_low) begin
            miso_byte <= block_reg ? `DPFS_FILL_BYTE : tx_byte;
        end
    end

    // ------------------------------------------------------------
    // Port control
    // ------------------------------------------------------------
    assign manual_on = (unlock_reg == `DPFS_UNLOCK_CODE) && ctrl_reg[`DPFS_CTRL_OVR_BIT];
    assign port_en = manual_on ? ctrl_reg[`DPFS_CTRL_EN_LSB +: 4] : auto_port_en;
    assign low_side_tx_active = port_en[3];
    assign low_side_rx_active = port_en[2];
    assign high_side_tx_active = port_en[1];
    assign high_side_rx_active = port_en[0];

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign idx = paddr[17:2];
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign hit = (idx == `DPFS_IDX_PORT_STAT) || (idx == `DPFS_IDX_PHY_FAULT) || (idx == `DPFS_IDX_IRQ_MASK)
                 || (idx == `DPFS_IDX_DEBUG_CTRL) || (idx == `DPFS_IDX_UNLOCK);
    assign pslverr = psel && penable && !hit;

    // Unlock code register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_reg <= 8'h00;
        end else if (wr_en && idx == `DPFS_IDX_UNLOCK) begin
            unlock_reg <= pwdata[7:0];
        end
    end

    // Debug control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `DPFS_CTRL_RESET;
        end else if (wr_en && idx == `DPFS_IDX_DEBUG_CTRL) begin
            ctrl_reg <= {1'b0, pwdata[6:0]};
        end
    end

    // Interrupt mask register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= '0;
        end else if (wr_en && idx == `DPFS_IDX_IRQ_MASK) begin
            mask_reg <= pwdata[6:0];
        end
    end

    // Read data registered in setup, valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (idx)
                `DPFS_IDX_PORT_STAT: prdata <= {27'h0, !manual_on, port_en};
                `DPFS_IDX_PHY_FAULT: prdata <= {25'h0, fault_flag};
                `DPFS_IDX_IRQ_MASK: prdata <= {25'h0, mask_reg};
                `DPFS_IDX_DEBUG_CTRL: prdata <= {24'h0, ctrl_reg};
                `DPFS_IDX_UNLOCK: prdata <= {24'h0, unlock_reg};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Level interrupt from faults whose mask bit is clear
    assign irq = |(fault_flag & ~mask_reg);
endmodule : dpfs_top

// file: sim/dpfs_host_model.sv
/*
 * Host controller model driving the serial strobes.
 * Assumes the bench calls its tasks; shares pclk.
 */
`timescale 1ns/1ps
module dpfs_host_model (
    // Clock
    input wire logic pclk,
    // Strobes to the device
    output logic chip_select_low,
    output logic sclk_pulse,
    output logic host_write_byte,
    output logic clear_good,
    output logic clear_bad
);
// Idle at time zero
initial begin
    {chip_select_low, sclk_pulse, host_write_byte, clear_good, clear_bad} = '0;
end
// One select period of n clocks, gap idle cycles between clocks
task automatic frame(input int n, input bit wr, input int gap);
    @(posedge pclk);
    chip_select_low <= 1'h1;
    for (int i = 0; i < n; i++) begin
        @(posedge pclk);
        sclk_pulse <= 1'h1;
        host_write_byte <= wr && (i % 8 == 7);
        repeat (gap) begin
            @(posedge pclk);
            sclk_pulse <= 1'h0;
            host_write_byte <= 1'h0;
        end
    end
    @(posedge pclk);
    {chip_select_low, sclk_pulse, host_write_byte} <= '0;
    @(posedge pclk);
endtask : frame
// Communication clear, well formed or not
task automatic clr(input bit good);
    @(posedge pclk);
    clear_good <= good;
    clear_bad <= !good;
    @(posedge pclk);
    {clear_good, clear_bad} <= '0;
endtask : clr
endmodule : dpfs_host_model

// file: sim/dpfs_top_monitor.sv
/*
 * Checker for the fault masking and fill byte of dpfs_top.
 * Assumes it is bound to dpfs_top and sees its ports only.
 */
`timescale 1ns/1ps
module dpfs_top_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host strobes and queue levels
    input wire logic chip_select_low,
    input wire logic sclk_pulse,
    input wire logic clear_good,
    input wire logic clear_bad,
    input wire logic host_write_byte,
    input wire logic resp_pending,
    input wire logic fifo_empty,
    input wire logic fifo_full,
    input wire logic rx_too_many,
    input wire logic [7:0] tx_byte,
    // Data path
    input wire logic store_en,
    input wire logic host_ready,
    input wire dpfs_pkg::dpfs_byte_t miso_byte
);
import dpfs_pkg::*;
// ----------
// Properties
// ----------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
// Causes close the data path one cycle later; a bad clear closes it in the same cycle
property p_txof; host_write_byte && fifo_full |=> !store_en && !host_ready; endproperty
a_txof: assert property (p_txof) else $error("tx overflow kept path open");
property p_uf; sclk_pulse && fifo_empty && !host_write_byte |=> !store_en && !host_ready; endproperty
a_uf: assert property (p_uf) else $error("underflow kept path open");
property p_rof; rx_too_many |=> !store_en && !host_ready; endproperty
a_rof: assert property (p_rof) else $error("rx overflow kept path open");
property p_uwr; host_write_byte && resp_pending |=> !store_en; endproperty
a_uwr: assert property (p_uwr) else $error("unexpected write kept storing");
property p_badclr; clear_bad |-> !store_en && !host_ready; endproperty
a_badclr: assert property (p_badclr) else $error("bad clear let data through");
// Mask holds until a good clear
property p_hold; !store_en && !clear_bad && !clear_good |=> !store_en; endproperty
a_hold: assert property (p_hold) else $error("store mask dropped early");
property p_rdy; !host_ready && !clear_bad && !clear_good |=> !host_ready; endproperty
a_rdy: assert property (p_rdy) else $error("ready rose without clear");
// Byte reload picks fill or response
property p_fill; !chip_select_low && !store_en && !clear_bad |=> miso_byte == 8'hFF; endproperty
a_fill: assert property (p_fill) else $error("masked byte not fill");
property p_pass; !chip_select_low && store_en |=> miso_byte == $past(tx_byte); endproperty
a_pass: assert property (p_pass) else $error("open path lost response byte");
endmodule : dpfs_top_monitor
bind dpfs_top dpfs_top_monitor u_mon (
    .pclk(pclk),
    .presetn(presetn),
    .chip_select_low(chip_select_low),
    .sclk_pulse(sclk_pulse),
    .clear_good(clear_good),
    .clear_bad(clear_bad),
    .host_write_byte(host_write_byte),
    .resp_pending(resp_pending),
    .fifo_empty(fifo_empty),
    .fifo_full(fifo_full),
    .rx_too_many(rx_too_many),
    .tx_byte(tx_byte),
    .store_en(store_en),
    .host_ready(host_ready),
    .miso_byte(miso_byte)
);

// file: sim/tb_spi_host_fault_and_link_status.sv
/*
 * Self-checking bench for dpfs_top with the host model.
 * Assumes the monitor is bound by its own file.
 */
`timescale 1ns/1ps
`include "dpfs_defines.svh"
module tb_spi_host_fault_and_link_status;
logic pclk = 1'h0;
logic presetn = 1'h0;
logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
logic [17:0] paddr = '0;
logic [31:0] pwdata = '0, prdata;
logic resp_pending = 1'h0, fifo1_empty = 1'h0, fifo_empty = 1'h0, fifo_full = 1'h0, rx_too_many = 1'h0;
logic [7:0] tx_byte = 8'h5C;
logic [3:0] auto_port_en = 4'h3;
logic pready, pslverr, chip_select_low, sclk_pulse, clear_good, clear_bad, host_write_byte, store_en, host_ready, irq;
logic low_side_tx_active, low_side_rx_active, high_side_tx_active, high_side_rx_active;
dpfs_pkg::dpfs_byte_t miso_byte;
int failures = 0, samples_checked = 0;
localparam logic [4:0] LV [4] = '{5'h01, 5'h02, 5'h0C, 5'h10};
localparam logic [7:0] EX [4] = '{8'h01, 8'h04, 8'h0A, 8'h10};
localparam logic [3:0] WR = 4'hA;
wire [3:0] act = {low_side_tx_active, low_side_rx_active, high_side_tx_active, high_side_rx_active};
// -------------------
// Clock and instances
// -------------------
always #2.5 pclk = ~pclk;
dpfs_top uut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .chip_select_low(chip_select_low),
    .sclk_pulse(sclk_pulse),
    .clear_good(clear_good),
    .clear_bad(clear_bad),
    .host_write_byte(host_write_byte),
    .resp_pending(resp_pending),
    .fifo1_empty(fifo1_empty),
    .fifo_full(fifo_full),
    .fifo_empty(fifo_empty),
    .rx_too_many(rx_too_many),
    .tx_byte(tx_byte),
    .auto_port_en(auto_port_en),
    .low_side_tx_active(low_side_tx_active),
    .low_side_rx_active(low_side_rx_active),
    .high_side_tx_active(high_side_tx_active),
    .high_side_rx_active(high_side_rx_active),
    .store_en(store_en),
    .host_ready(host_ready),
    .miso_byte(miso_byte),
    .irq(irq)
);
dpfs_host_model host (
    .pclk(pclk),
    .chip_select_low(chip_select_low),
    .sclk_pulse(sclk_pulse),
    .host_write_byte(host_write_byte),
    .clear_good(clear_good),
    .clear_bad(clear_bad)
);
// Compare and count
task cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
        failures++;
        $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
endtask : cmp
// One APB transfer, waiting for pready
task apb(input logic w, input logic [15:0] idx, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
endtask : apb
task rd(input logic [15:0] idx, input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'h0, idx, 32'h0, r, e);
    cmp(r, ex);
    cmp(e, 1'h0);
endtask : rd
task wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, idx, d, r, e);
endtask : wr
// Port source and live enables
task t_ports;
    logic [31:0] r;
    logic e;
    rd(`DPFS_IDX_PORT_STAT, 32'h13);
    wr(`DPFS_IDX_DEBUG_CTRL, 32'h79);
    rd(`DPFS_IDX_PORT_STAT, 32'h13);
    wr(`DPFS_IDX_UNLOCK, 32'hA5);
    rd(`DPFS_IDX_PORT_STAT, 32'h0F);
    cmp(act, 4'hF);
    wr(`DPFS_IDX_DEBUG_CTRL, 32'h29);
    rd(`DPFS_IDX_PORT_STAT, 32'h05);
    cmp(act, 4'h5);
    wr(`DPFS_IDX_UNLOCK, 32'h5A);
    @(posedge pclk);
    auto_port_en <= 4'hA;
    wr(`DPFS_IDX_PORT_STAT, 32'hFF);
    rd(`DPFS_IDX_PORT_STAT, 32'h1A);
    cmp(act, 4'hA);
    apb(1'h0, 16'h2302, 32'h0, r, e);
    cmp(e, 1'h1);
    cmp(r, 32'h0);
endtask : t_ports
// Data path faults, bad clear while masked, recovery
task t_faults;
    for (int k = 0; k < 4; k++) begin
        @(posedge pclk);
        {resp_pending, fifo1_empty, fifo_empty, fifo_full, rx_too_many} <= LV[k];
        host.frame(8, WR[k], k);
        #1;
        cmp(store_en, 1'h0);
        cmp(host_ready, 1'h0);
        cmp(miso_byte, 8'hFF);
        cmp(irq, 1'h1);
        @(posedge pclk);
        {resp_pending, fifo1_empty, fifo_empty, fifo_full, rx_too_many} <= 5'h0;
        host.clr(1'h0);
        #1;
        cmp(store_en, 1'h0);
        host.clr(1'h1);
        #1;
        cmp(host_ready, 1'h1);
        rd(`DPFS_IDX_PHY_FAULT, {24'h0, EX[k] | 8'h20});
        wr(`DPFS_IDX_PHY_FAULT, 32'hFF);
        rd(`DPFS_IDX_PHY_FAULT, 32'h0);
        cmp(irq, 1'h0);
        cmp(miso_byte, 8'h5C);
    end
endtask : t_faults
// Odd bit count, masked interrupt, whole frame
task t_fmt;
    wr(`DPFS_IDX_IRQ_MASK, 32'h40);
    host.frame(9, 1'h0, 1);
    repeat (4) @(posedge pclk);
    rd(`DPFS_IDX_PHY_FAULT, 32'h40);
    cmp(irq, 1'h0);
    wr(`DPFS_IDX_IRQ_MASK, 32'h0);
    #1;
    cmp(irq, 1'h1);
    wr(`DPFS_IDX_PHY_FAULT, 32'h40);
    host.frame(16, 1'h1, 0);
    repeat (4) @(posedge pclk);
    rd(`DPFS_IDX_PHY_FAULT, 32'h0);
    cmp(store_en, 1'h1);
endtask : t_fmt
// Verdict and end of run
task wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
        $display("Simulation passed");
    end else begin
        $display("Simulation failed");
    end
    $finish;
endtask : wrap_up
// Main sequence
initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    rd(`DPFS_IDX_PHY_FAULT, 32'h0);
    rd(`DPFS_IDX_DEBUG_CTRL, 32'h78);
    wr(`DPFS_IDX_IRQ_MASK, 32'h0);
    t_ports();
    t_faults();
    t_fmt();
    wrap_up();
end
// Watchdog
initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    wrap_up();
end
endmodule : tb_spi_host_fault_and_link_status
